// file: design/tsr_id_cfg_regs.sv
// identity and bus configuration registers with alert, flag and time-out control
`timescale 1ns/1ps
`default_nettype none
module tsr_id_cfg_regs
  import tsr_pkg::*;
#(
  parameter logic [7:0]  DEVICE_CODE  = 8'h5C,   // arbitrary value
  parameter logic [7:0]  REVISION     = 8'h01,   // arbitrary value
  parameter logic [15:0] MAKER_CODE   = 16'h0ABC, // arbitrary value
  parameter int          LIMIT_CYCLES = TIMEOUT_CYCLES
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [REG_ADDR_W-1:0] regAddr,
  input  wire logic [REG_DATA_W-1:0] regWdata,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  output var  logic [REG_DATA_W-1:0] regRdata,
  input  wire logic                  sclPin,
  input  wire logic                  lockCritical,
  input  wire logic                  lockAlarm,
  input  wire logic                  sensorShutdown,
  input  wire logic                  conversionDone,
  input  wire logic                  comparatorMode,
  input  wire logic                  alertPolarityHigh,
  input  wire logic                  alertRaw,
  input  wire tsr_flags_t            flagsRaw,
  input  wire logic                  intClearReq,
  output var  tsr_flags_t            flags,
  output var  tsr_cfg_t              cfg,
  output var  logic                  timeoutActive,
  output var  logic                  busTimeout,
  output logic                       intClearGrant,
  output var  logic                  alertLevel,
  output logic                       alertOut,
  output logic                       alertOe,
  output logic                       irq
);
  logic [15:0]      cfgWord;
  logic [15:0]      next_cfgWord;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] next_irqStatus;
  logic [IRQ_W-1:0] irqMask;
  logic [IRQ_W-1:0] next_irqMask;
  logic [15:0]      next_regRdata;
  tsr_flags_t       next_flags;
  logic             next_alertLevel;
  logic             next_timeoutActive;
  logic             shdnPrev;
  logic             holdAfterShdn;
  logic             next_holdAfterShdn;
  logic             sclSync;
  logic             timeoutPulse;
  logic             locked;
  logic             cfgWrite;
  logic             enterShdn;
  logic             exitShdn;
  logic             clearBlocked;

  initial begin
    if (LIMIT_CYCLES < 2) $error("tsr_id_cfg_regs: LIMIT_CYCLES must be at least 2");
  end

  tsr_sync2 #(
    .WIDTH (1)
  ) u_scl_sync (
    .clock  (clock),
    .rst    (rst),
    .async  (sclPin),
    .synced (sclSync)
  );

  tsr_scl_timeout #(
    .LIMIT_CYCLES (LIMIT_CYCLES)
  ) u_timeout (
    .clock        (clock),
    .rst          (rst),
    .sclLevel     (sclSync),
    .enable       (timeoutActive),
    .timeoutPulse (timeoutPulse)
  );

  assign locked    = lockCritical | lockAlarm;
  assign cfgWrite  = regWrite && (regAddr == ADDR_BUS_CFG);
  assign enterShdn = sensorShutdown & ~shdnPrev;
  assign exitShdn  = ~sensorShutdown & shdnPrev;

  assign cfg.timeoutOff           = cfgWord[CFG_TIMEOUT_OFF_BIT];
  assign cfg.shutdownTimeoutKeep  = cfgWord[CFG_SHDN_TO_KEEP_BIT];
  assign cfg.alertPinSleepState   = cfgWord[CFG_SLEEP_STATE_BIT];
  assign cfg.comparatorClearBlock = cfgWord[CFG_CLEAR_BLOCK_BIT];
  assign cfg.flagRefreshSelect    = cfgWord[CFG_FLAG_REFRESH_BIT];
  assign cfg.alertResponseOff     = cfgWord[CFG_ARA_OFF_BIT];

  // host clear of the interrupt flop, refused in comparator mode when blocked
  assign clearBlocked  = intClearReq & comparatorMode & cfg.comparatorClearBlock;
  assign intClearGrant = intClearReq & ~clearBlocked;

  // open-drain alert pin: pull low for a low level
  assign alertOut = 1'b0;
  assign alertOe  = ~alertLevel;
  assign irq      = |(irqStatus & irqMask);

  // register file
  always_comb begin
    next_cfgWord   = cfgWord;
    next_irqMask   = irqMask;
    next_irqStatus = irqStatus;
    next_regRdata  = 16'h0000;
    if (cfgWrite && !locked) begin
      next_cfgWord = regWdata & CFG_WRITABLE;
    end
    if (regWrite && regAddr == ADDR_IRQ_MASK) begin
      next_irqMask = regWdata[IRQ_W-1:0];
    end
    if (regWrite && regAddr == ADDR_IRQ_STATUS) begin
      next_irqStatus = irqStatus & ~regWdata[IRQ_W-1:0];
    end
    // new events win over a clear in the same cycle
    if (timeoutPulse) begin
      next_irqStatus[IRQ_TIMEOUT_BIT] = 1'b1;
    end
    if (cfgWrite && locked) begin
      next_irqStatus[IRQ_LOCKED_WR_BIT] = 1'b1;
    end
    if (clearBlocked) begin
      next_irqStatus[IRQ_CLR_BLOCK_BIT] = 1'b1;
    end
    if (regRead) begin
      case (regAddr)
        ADDR_MAKER_ID:   next_regRdata = MAKER_CODE;
        ADDR_DEVICE_ID:  next_regRdata = {DEVICE_CODE, REVISION};
        ADDR_BUS_CFG:    next_regRdata = cfgWord & CFG_WRITABLE;
        ADDR_IRQ_STATUS: next_regRdata = {{(16-IRQ_W){1'b0}}, irqStatus};
        ADDR_IRQ_MASK:   next_regRdata = {{(16-IRQ_W){1'b0}}, irqMask};
        default:         next_regRdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfgWord   <= CFG_RESET;
      irqStatus <= IRQ_RESET;
      irqMask   <= IRQ_RESET;
      regRdata  <= 16'h0000;
    end else begin
      cfgWord   <= next_cfgWord;
      irqStatus <= next_irqStatus;
      irqMask   <= next_irqMask;
      regRdata  <= next_regRdata;
    end
  end

  // time-out enable, flags and alert pin
  always_comb begin
    next_timeoutActive = ~cfg.timeoutOff
                       & (~sensorShutdown | cfg.shutdownTimeoutKeep);
    next_flags = flags;
    if (enterShdn || sensorShutdown) begin
      next_flags = '0;
    end else if (!cfg.flagRefreshSelect || conversionDone) begin
      next_flags = flagsRaw;
    end
    next_holdAfterShdn = holdAfterShdn;
    if (conversionDone) begin
      next_holdAfterShdn = 1'b0;
    end
    if (exitShdn) begin
      next_holdAfterShdn = 1'b1;
    end
    next_alertLevel = alertLevel;
    if (sensorShutdown) begin
      if (cfg.alertPinSleepState) begin
        next_alertLevel = ~alertPolarityHigh;
      end
    end else if (!next_holdAfterShdn) begin
      next_alertLevel = alertRaw;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      timeoutActive <= 1'b1;
      flags         <= '0;
      holdAfterShdn <= 1'b0;
      alertLevel    <= 1'b1;
      shdnPrev      <= 1'b0;
      busTimeout    <= 1'b0;
    end else begin
      timeoutActive <= next_timeoutActive;
      flags         <= next_flags;
      holdAfterShdn <= next_holdAfterShdn;
      alertLevel    <= next_alertLevel;
      shdnPrev      <= sensorShutdown;
      busTimeout    <= timeoutPulse;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_exit_shdn;
    shdnPrev && !sensorShutdown;
  endsequence

  sequence s_no_conversion;
    !conversionDone;
  endsequence

  property p_device_id;
    regRead && regAddr == ADDR_DEVICE_ID |=> regRdata == {DEVICE_CODE, REVISION};
  endproperty
  a_device_id: assert property (p_device_id)
    else $error("identity word read back wrong");

  property p_cfg_write;
    cfgWrite && !locked |=> cfgWord == ($past(regWdata) & CFG_WRITABLE);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("unlocked config write not stored");

  property p_timeout_off;
    cfg.timeoutOff |=> !timeoutActive;
  endproperty
  a_timeout_off: assert property (p_timeout_off)
    else $error("time-out active while disabled");

  property p_lock_freeze;
    cfgWrite && locked |=> $stable(cfgWord);
  endproperty
  a_lock_freeze: assert property (p_lock_freeze)
    else $error("config changed under lock");

  property p_lock_ara;
    cfgWrite && locked ##1 !cfgWrite |=> cfg.alertResponseOff == $past(cfg.alertResponseOff, 2);
  endproperty
  a_lock_ara: assert property (p_lock_ara)
    else $error("alert response bit changed under lock");

  property p_shdn_timeout;
    !cfg.timeoutOff && sensorShutdown && !cfg.shutdownTimeoutKeep |=> !timeoutActive;
  endproperty
  a_shdn_timeout: assert property (p_shdn_timeout)
    else $error("time-out active in shutdown while not kept");

  property p_timeout_on;
    !cfg.timeoutOff && (!sensorShutdown || cfg.shutdownTimeoutKeep) |=> timeoutActive;
  endproperty
  a_timeout_on: assert property (p_timeout_on)
    else $error("time-out inactive while enabled");

  property p_sleep_state;
    sensorShutdown && cfg.alertPinSleepState |=> alertLevel != $past(alertPolarityHigh);
  endproperty
  a_sleep_state: assert property (p_sleep_state)
    else $error("alert pin not inactive in shutdown");

  property p_clear_block;
    intClearReq && comparatorMode && cfg.comparatorClearBlock |-> !intClearGrant
      ##1 irqStatus[IRQ_CLR_BLOCK_BIT];
  endproperty
  a_clear_block: assert property (p_clear_block)
    else $error("comparator clear not blocked");

  property p_flag_hold;
    cfg.flagRefreshSelect && !sensorShutdown && !conversionDone |=> $stable(flags);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flags moved without conversion");

  property p_shdn_clear;
    enterShdn |=> flags == '0;
  endproperty
  a_shdn_clear: assert property (p_shdn_clear)
    else $error("flags not cleared on shutdown entry");

  property p_exit_hold;
    s_exit_shdn ##0 s_no_conversion |=> $stable(alertLevel);
  endproperty
  a_exit_hold: assert property (p_exit_hold)
    else $error("alert pin moved before first conversion");

  property p_reserved;
    regRead && regAddr == ADDR_BUS_CFG |=> regRdata[15:8] == 8'h00 && !regRdata[6] && !regRdata[1];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved config bits not zero");

  property p_timeout_event;
    timeoutPulse |=> busTimeout && irqStatus[IRQ_TIMEOUT_BIT];
  endproperty
  a_timeout_event: assert property (p_timeout_event)
    else $error("time-out event not reported");

  property p_clear_grant;
    intClearReq && !(comparatorMode && cfg.comparatorClearBlock) |-> intClearGrant;
  endproperty
  a_clear_grant: assert property (p_clear_grant)
    else $error("allowed interrupt clear refused");

  property p_flag_follow;
    !cfg.flagRefreshSelect && !sensorShutdown |=> flags == $past(flagsRaw);
  endproperty
  a_flag_follow: assert property (p_flag_follow)
    else $error("flags not refreshed continuously");

  property p_hold_after_exit;
    holdAfterShdn && !sensorShutdown && !conversionDone |=> $stable(alertLevel);
  endproperty
  a_hold_after_exit: assert property (p_hold_after_exit)
    else $error("alert pin released before first conversion");
endmodule
`default_nettype wire

// file: pkg/tsr_pkg.sv
// constants, field layout and carrier types of the sensor id and bus config registers
`default_nettype none
package tsr_pkg;
  localparam int REG_ADDR_W = 8;
  localparam int REG_DATA_W = 16;

  localparam logic [7:0] ADDR_MAKER_ID   = 8'h06;
  localparam logic [7:0] ADDR_DEVICE_ID  = 8'h07;
  localparam logic [7:0] ADDR_BUS_CFG    = 8'h22;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h31;

  localparam int CFG_TIMEOUT_OFF_BIT   = 7;
  localparam int CFG_SHDN_TO_KEEP_BIT  = 5;
  localparam int CFG_SLEEP_STATE_BIT   = 4;
  localparam int CFG_CLEAR_BLOCK_BIT   = 3;
  localparam int CFG_FLAG_REFRESH_BIT  = 2;
  localparam int CFG_ARA_OFF_BIT       = 0;
  localparam logic [15:0] CFG_WRITABLE = 16'h00BD;
  localparam logic [15:0] CFG_RESET    = 16'h0031;

  localparam int IRQ_W              = 3;
  localparam int IRQ_TIMEOUT_BIT    = 0;
  localparam int IRQ_LOCKED_WR_BIT  = 1;
  localparam int IRQ_CLR_BLOCK_BIT  = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  localparam int CLK_PERIOD_NS  = 20;
  localparam int TIMEOUT_US     = 30;
  localparam int TIMEOUT_CYCLES = (TIMEOUT_US * 1000) / CLK_PERIOD_NS;

  typedef struct packed {
    logic timeoutOff;
    logic shutdownTimeoutKeep;
    logic alertPinSleepState;
    logic comparatorClearBlock;
    logic flagRefreshSelect;
    logic alertResponseOff;
  } tsr_cfg_t;

  typedef struct packed {
    logic aboveCriticalFlag;
    logic aboveWindowFlag;
    logic belowWindowFlag;
  } tsr_flags_t;
endpackage
`default_nettype wire

// file: design/tsr_sync2.sv
// two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module tsr_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async,
  output var  logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage1;

  initial begin
    if (WIDTH < 1) $error("tsr_sync2: WIDTH must be at least 1");
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stage1 <= '1;
      synced <= '1;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end
endmodule
`default_nettype wire

// file: design/tsr_scl_timeout.sv
// counts how long the sampled link clock stays low, one pulse at the limit
`timescale 1ns/1ps
`default_nettype none
module tsr_scl_timeout #(
  parameter int LIMIT_CYCLES = 1500
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic sclLevel,
  input  wire logic enable,
  output var  logic timeoutPulse
);
  localparam int CW = $clog2(LIMIT_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(LIMIT_CYCLES);

  logic          sclPrev;
  logic [CW-1:0] lowCount;
  logic [CW-1:0] next_lowCount;
  logic          next_timeoutPulse;

  initial begin
    if (LIMIT_CYCLES < 2) $error("tsr_scl_timeout: LIMIT_CYCLES must be at least 2");
  end

  always_comb begin
    next_lowCount     = lowCount;
    next_timeoutPulse = 1'b0;
    if (!enable || sclLevel || sclPrev) begin
      // a falling edge restarts the measurement
      next_lowCount = '0;
    end else if (lowCount != LIMIT) begin
      next_lowCount     = lowCount + CW'(1);
      next_timeoutPulse = (lowCount == LIMIT - CW'(1));
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sclPrev      <= 1'b1;
      lowCount     <= '0;
      timeoutPulse <= 1'b0;
    end else begin
      sclPrev      <= sclLevel;
      lowCount     <= next_lowCount;
      timeoutPulse <= next_timeoutPulse;
    end
  end
endmodule
`default_nettype wire

// file: tb/tsr_host_link.sv
// host side model of the link clock: toggles in frames, can stall it low
`timescale 1ns/1ps
`default_nettype none
module tsr_host_link (
  input  wire logic frame,
  input  wire logic stall,
  output var  logic scl
);
  initial begin
    scl = 1'b1;
    forever begin
      #80;
      if (stall) begin
        scl = 1'b0;
      end else if (frame) begin
        scl = ~scl;
      end else begin
        scl = 1'b1; // released line sits at pull-up level
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/thermal_sensor_id_and_bus_config_regs_tb_top.sv
// self-checking bench of the id and bus configuration registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module thermal_sensor_id_and_bus_config_regs_tb_top
  import tsr_pkg::*;
;
  logic        clock, rst, regWrite, regRead, sclPin, lockCritical, lockAlarm;
  logic        sensorShutdown, conversionDone, comparatorMode, alertPolarityHigh;
  logic        alertRaw, intClearReq, timeoutActive, busTimeout, intClearGrant;
  logic        alertLevel, alertOut, alertOe, irq, frame, stall;
  logic [7:0]  regAddr;
  logic [15:0] regWdata, regRdata;
  tsr_flags_t  flagsRaw, flags;
  tsr_cfg_t    cfg;
  int          n_errors, n_compared, cycles, n_pulses;

  tsr_id_cfg_regs #(.LIMIT_CYCLES(8)) dut (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .sclPin(sclPin),
    .lockCritical(lockCritical), .lockAlarm(lockAlarm), .sensorShutdown(sensorShutdown),
    .conversionDone(conversionDone), .comparatorMode(comparatorMode),
    .alertPolarityHigh(alertPolarityHigh), .alertRaw(alertRaw), .flagsRaw(flagsRaw),
    .intClearReq(intClearReq), .flags(flags), .cfg(cfg), .timeoutActive(timeoutActive),
    .busTimeout(busTimeout), .intClearGrant(intClearGrant), .alertLevel(alertLevel),
    .alertOut(alertOut), .alertOe(alertOe), .irq(irq));

  tsr_host_link host (.frame(frame), .stall(stall), .scl(sclPin));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (busTimeout) begin
      n_pulses++;
    end
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic wait_c(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    `CHK(regRdata, e)
  endtask

  task automatic pulse_conv();
    @(posedge clock) conversionDone <= 1'b1;
    @(posedge clock) conversionDone <= 1'b0;
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    n_errors = 0; n_compared = 0; cycles = 0; n_pulses = 0;
    rst = 1'b1; regWrite = 1'b0; regRead = 1'b0; regAddr = 8'h00; regWdata = 16'h0000;
    lockCritical = 1'b0; lockAlarm = 1'b0; sensorShutdown = 1'b0; conversionDone = 1'b0;
    comparatorMode = 1'b0; alertPolarityHigh = 1'b0; alertRaw = 1'b0;
    intClearReq = 1'b0; flagsRaw = 3'h0; frame = 1'b0; stall = 1'b0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    // identity and reset values
    rdchk(ADDR_DEVICE_ID, 16'h5C01);
    rdchk(ADDR_MAKER_ID, 16'h0ABC);
    rdchk(ADDR_BUS_CFG, 16'h0031);
    rdchk(8'h40, 16'h0000);
    `CHK(timeoutActive, 1'b1)
    `CHK(cfg, 6'h19)
    wr(ADDR_DEVICE_ID, 16'hFFFF);
    rdchk(ADDR_DEVICE_ID, 16'h5C01);
    tend("identity");
    // writable mask and time-out off
    wr(ADDR_BUS_CFG, 16'hFFFF);
    rdchk(ADDR_BUS_CFG, 16'h00BD);
    wait_c(2);
    `CHK(timeoutActive, 1'b0)
    tend("config write");
    // locks freeze every writable bit
    @(posedge clock) lockCritical <= 1'b1;
    wr(ADDR_BUS_CFG, 16'h0000);
    rdchk(ADDR_BUS_CFG, 16'h00BD);
    @(posedge clock) begin
      lockCritical <= 1'b0;
      lockAlarm    <= 1'b1;
    end
    wr(ADDR_BUS_CFG, 16'h0000);
    rdchk(ADDR_BUS_CFG, 16'h00BD);
    rdchk(ADDR_IRQ_STATUS, 16'h0002);
    wr(ADDR_IRQ_STATUS, 16'h0002);
    @(posedge clock) lockAlarm <= 1'b0;
    wr(ADDR_BUS_CFG, 16'h0000);
    rdchk(ADDR_BUS_CFG, 16'h0000);
    tend("locks");
    // time-out enable against shutdown
    @(posedge clock) sensorShutdown <= 1'b1;
    wait_c(3);
    `CHK(timeoutActive, 1'b0)
    wr(ADDR_BUS_CFG, 16'h0020);
    wait_c(3);
    `CHK(timeoutActive, 1'b1)
    wr(ADDR_BUS_CFG, 16'h00A0);
    wait_c(3);
    `CHK(timeoutActive, 1'b0)
    @(posedge clock) sensorShutdown <= 1'b0;
    wr(ADDR_BUS_CFG, 16'h0020);
    tend("timeout enable");
    // link stall raises the time-out event and interrupt
    wr(ADDR_IRQ_MASK, 16'h0001);
    frame = 1'b1;
    wait_c(40);
    frame = 1'b0;
    rdchk(ADDR_IRQ_STATUS, 16'h0000);
    stall = 1'b1;
    wait_c(30);
    stall = 1'b0;
    wait_c(12);
    rdchk(ADDR_IRQ_STATUS, 16'h0001);
    `CHK(irq, 1'b1)
    `CHK(n_pulses, 1)
    wr(ADDR_IRQ_STATUS, 16'h0001);
    wait_c(1);
    `CHK(irq, 1'b0)
    wr(ADDR_BUS_CFG, 16'h0080);
    stall = 1'b1;
    wait_c(30);
    stall = 1'b0;
    wait_c(12);
    rdchk(ADDR_IRQ_STATUS, 16'h0000);
    `CHK(n_pulses, 1)
    tend("link timeout");
    // comparator mode clear blocking
    @(posedge clock) comparatorMode <= 1'b1;
    wr(ADDR_BUS_CFG, 16'h0008);
    @(posedge clock) intClearReq <= 1'b1;
    #1;
    `CHK(intClearGrant, 1'b0)
    @(posedge clock) intClearReq <= 1'b0;
    rdchk(ADDR_IRQ_STATUS, 16'h0004);
    wr(ADDR_BUS_CFG, 16'h0000);
    @(posedge clock) intClearReq <= 1'b1;
    #1;
    `CHK(intClearGrant, 1'b1)
    @(posedge clock) intClearReq <= 1'b0;
    tend("clear mode");
    // flag refresh policy and shutdown clearing
    wr(ADDR_BUS_CFG, 16'h0004);
    @(posedge clock) flagsRaw <= 3'h7;
    wait_c(3);
    `CHK(flags, 3'h0)
    pulse_conv();
    wait_c(2);
    `CHK(flags, 3'h7)
    wr(ADDR_BUS_CFG, 16'h0000);
    @(posedge clock) flagsRaw <= 3'h5;
    wait_c(2);
    `CHK(flags, 3'h5)
    @(posedge clock) sensorShutdown <= 1'b1;
    wait_c(2);
    `CHK(flags, 3'h0)
    tend("flags");
    // alert pin in and after shutdown
    wr(ADDR_BUS_CFG, 16'h0010);
    wait_c(3);
    `CHK(alertLevel, 1'b1)
    `CHK(alertOe, 1'b0)
    wr(ADDR_BUS_CFG, 16'h0000);
    @(posedge clock) alertPolarityHigh <= 1'b1;
    wait_c(3);
    `CHK(alertLevel, 1'b1)
    @(posedge clock) sensorShutdown <= 1'b0;
    wait_c(4);
    `CHK(alertLevel, 1'b1)
    pulse_conv();
    wait_c(3);
    `CHK(alertLevel, 1'b0)
    `CHK(alertOe, 1'b1)
    `CHK(alertOut, 1'b0)
    tend("alert");
    print_verdict();
  end
endmodule
`default_nettype wire
